/* File: logic/dssw_status_regs.sv */
// Drive status word and scaled speed word behind an Avalon-MM slave
//
// Functional notes
// R1 - One shared status word, read only
// R2 - Bit 1 shows run command received
// R3 - Bit 2 shows emergency override active
// R4 - Bits 0, 3, 4, 14 reserved
// R5 - Bit 5 shows second ramp pair
// R6 - Bit 6 shows configuration state, no enable
// R7 - Bit 7 shows alarm state
// R8 - Bit 8 shows running per reference
// R9 - Bit 9 shows fully enabled
// R10 - Bit 10 shows forward direction
// R11 - Bit 11 shows inching active
// R12 - Bit 12 shows remote mode
// R13 - Bit 13 undervoltage, bit 15 fault
// R14 - Speed word is signed 16 bit
// R15 - Rated frequency reads as 8192
// R16 - Most positive value is four times rated
// R17 - Zero speed reads zero
// R18 - Scaling uses rated frequency, not speed
// R19 - Reserved bits read zero
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module dssw_status_regs
   import dssw_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Drive conditions and present output frequency
   input wire dssw_cond_t cond,
   input wire logic signed [W-1:0] outputFreq,
   // Status outputs
   output logic [15:0] statusWord,
   output logic [W-1:0] scaledSpeed,
   output logic irq
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic ack;
   logic request;
   logic writeTaken;
   logic [W-1:0] ratedFreq;
   logic [W-1:0] ratedSpeed;
   logic [DSSW_EV_W-1:0] eventStatus;
   logic [DSSW_EV_W-1:0] eventMask;
   logic [DSSW_EV_W-1:0] eventSet;
   logic [DSSW_EV_W-1:0] eventClear;
   logic [15:0] next_statusWord;
   logic [15:0] prevStatus;
   logic statusValid;
   logic [W-1:0] scalerSpeed;
   logic scalerDone;
   logic ratedInvalid;
   logic [31:0] next_readdata;

   // ****************************************************************
   // Bus handshake
   // ****************************************************************
   // Every access waits exactly one cycle, then completes
   assign request = read | write;
   assign waitrequest = request & ~ack;
   assign writeTaken = write & ack;

   // Acknowledge toggles high for one cycle per access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
      end else begin
         ack <= request & ~ack;
      end
   end

   // ****************************************************************
   // Byte lane merge
   // ****************************************************************
   // Apply the low two byte enables to a 16-bit register
   function automatic logic [15:0] dssw_merge16(input logic [15:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] be);
      logic [15:0] result;
      result = old;
      if (be[0]) begin
         result[7:0] = data[7:0];
      end
      if (be[1]) begin
         result[15:8] = data[15:8];
      end
      return result;
   endfunction : dssw_merge16

   // Apply byte enables to a register of event width
   function automatic logic [DSSW_EV_W-1:0] dssw_merge_ev(input logic [DSSW_EV_W-1:0] old,
                                                          input logic [31:0] data,
                                                          input logic [3:0] be);
      logic [15:0] wide;
      wide = dssw_merge16({{(16-DSSW_EV_W){1'b0}}, old}, data, be);
      return wide[DSSW_EV_W-1:0];
   endfunction : dssw_merge_ev

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   // Rated frequency steers the speed scaler
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ratedFreq <= DSSW_RST_RATED_FREQ;
      end else if (writeTaken && address == DSSW_OFS_RATED_FREQ) begin
         ratedFreq <= dssw_merge16(ratedFreq, writedata, byteenable); // R18
      end
   end

   // Rated speed is held for software only, never used for scaling
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ratedSpeed <= DSSW_RST_RATED_SPEED;
      end else if (writeTaken && address == DSSW_OFS_RATED_SPEED) begin
         ratedSpeed <= dssw_merge16(ratedSpeed, writedata, byteenable); // R18
      end
   end

   // Interrupt mask, same layout as the event register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eventMask <= DSSW_RST_MASK;
      end else if (writeTaken && address == DSSW_OFS_MASK) begin
         eventMask <= dssw_merge_ev(eventMask, writedata, byteenable);
      end
   end

   // ****************************************************************
   // Logical status word
   // ****************************************************************
   // A zero rated frequency is an incompatible setting
   assign ratedInvalid = (ratedFreq == '0);

   // Assemble the word, reserved bits forced low
   always_comb begin
      next_statusWord = 16'h0000; // R4 R19
      next_statusWord[DSSW_ST_RUN_CMD] = cond.runCommand; // R2
      next_statusWord[DSSW_ST_OVERRIDE] = cond.overrideActive; // R3
      next_statusWord[DSSW_ST_SECOND_RAMP] = cond.secondRamp; // R5
      next_statusWord[DSSW_ST_CONFIG] = cond.configState | ratedInvalid; // R6
      next_statusWord[DSSW_ST_ALARM] = cond.alarm; // R7
      next_statusWord[DSSW_ST_RUNNING] = cond.running; // R8
      // Configuration state blocks the enabled indication
      next_statusWord[DSSW_ST_ENABLED] = cond.enabled & ~(cond.configState | ratedInvalid); // R9
      next_statusWord[DSSW_ST_FORWARD] = cond.forward; // R10
      next_statusWord[DSSW_ST_INCHING] = cond.inchingActive; // R11
      next_statusWord[DSSW_ST_REMOTE] = cond.remote; // R12
      next_statusWord[DSSW_ST_UNDERVOLT] = cond.undervoltage; // R13
      next_statusWord[DSSW_ST_FAULT] = cond.fault; // R13
      next_statusWord = next_statusWord & ~DSSW_ST_RESERVED_MASK; // R19
   end

   // Status word register, refreshed every cycle, no bus write path
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         statusWord <= DSSW_RST_STATUS;
      end else begin
         statusWord <= next_statusWord; // R1
      end
   end

   // Previous word for edge detection, valid after first update
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prevStatus <= DSSW_RST_STATUS;
         statusValid <= 1'b0;
      end else begin
         prevStatus <= statusWord;
         statusValid <= 1'b1;
      end
   end

   // ****************************************************************
   // Scaled speed word
   // ****************************************************************
   // Sequential divider, new result every 32 cycles
   dssw_speed_scaler #(
      .W(W)
   ) speedScaler (
      .clk(clk),
      .rst(rst),
      .outputFreq(outputFreq),
      .ratedFreq(ratedFreq),
      .scaledSpeed(scalerSpeed),
      .done(scalerDone)
   );

   // Publish each new result
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scaledSpeed <= DSSW_RST_SPEED;
      end else if (scalerDone) begin
         scaledSpeed <= scalerSpeed; // R14 R15 R16 R17
      end
   end

   // ****************************************************************
   // Events and interrupt
   // ****************************************************************
   // Rising and falling conditions of interest
   always_comb begin
      eventSet = '0;
      if (statusValid) begin
         eventSet[DSSW_EV_FAULT] = statusWord[DSSW_ST_FAULT] & ~prevStatus[DSSW_ST_FAULT];
         eventSet[DSSW_EV_ALARM] = statusWord[DSSW_ST_ALARM] & ~prevStatus[DSSW_ST_ALARM];
         eventSet[DSSW_EV_UNDERVOLT] = statusWord[DSSW_ST_UNDERVOLT]
            & ~prevStatus[DSSW_ST_UNDERVOLT];
         eventSet[DSSW_EV_CONFIG] = statusWord[DSSW_ST_CONFIG] & ~prevStatus[DSSW_ST_CONFIG];
         eventSet[DSSW_EV_RUN_START] = statusWord[DSSW_ST_RUNNING]
            & ~prevStatus[DSSW_ST_RUNNING];
         eventSet[DSSW_EV_RUN_STOP] = ~statusWord[DSSW_ST_RUNNING]
            & prevStatus[DSSW_ST_RUNNING];
         eventSet[DSSW_EV_DIRECTION] = statusWord[DSSW_ST_FORWARD]
            ^ prevStatus[DSSW_ST_FORWARD];
         eventSet[DSSW_EV_REMOTE] = statusWord[DSSW_ST_REMOTE] ^ prevStatus[DSSW_ST_REMOTE];
      end
      eventSet[DSSW_EV_SPEED] = scalerDone & (scalerSpeed != scaledSpeed);
   end

   // Write one to clear
   always_comb begin
      eventClear = '0;
      if (writeTaken && address == DSSW_OFS_EVENT) begin
         eventClear = dssw_merge_ev('0, writedata, byteenable);
      end
   end

   // Sticky events, a new event wins over a clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eventStatus <= DSSW_RST_EVENT;
      end else begin
         eventStatus <= (eventStatus & ~eventClear) | eventSet;
      end
   end

   // Level interrupt while any unmasked event is pending
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((eventStatus & ~eventClear) | eventSet) & eventMask);
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Select the addressed register, unmapped reads return zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      case (address)
         DSSW_OFS_STATUS: begin
            next_readdata = {16'h0000, statusWord}; // R1
         end
         DSSW_OFS_SPEED: begin
            next_readdata = {16'h0000, scaledSpeed}; // R14
         end
         DSSW_OFS_RATED_FREQ: begin
            next_readdata = {16'h0000, ratedFreq};
         end
         DSSW_OFS_RATED_SPEED: begin
            next_readdata = {16'h0000, ratedSpeed};
         end
         DSSW_OFS_EVENT: begin
            next_readdata = {{(32-DSSW_EV_W){1'b0}}, eventStatus};
         end
         DSSW_OFS_MASK: begin
            next_readdata = {{(32-DSSW_EV_W){1'b0}}, eventMask};
         end
         default: begin
            next_readdata = 32'h0000_0000;
         end
      endcase
   end

   // Capture read data in the wait cycle, hold otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata <= 32'h0000_0000;
      end else if (read && !ack) begin
         readdata <= next_readdata;
      end
   end

endmodule : dssw_status_regs

/* File: logic/dssw_pkg.sv */
// Shared constants and types of the drive status and speed word block
package dssw_pkg;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [5:0] DSSW_OFS_STATUS = 6'h00;
   localparam logic [5:0] DSSW_OFS_SPEED = 6'h04;
   localparam logic [5:0] DSSW_OFS_RATED_FREQ = 6'h08;
   localparam logic [5:0] DSSW_OFS_RATED_SPEED = 6'h0c;
   localparam logic [5:0] DSSW_OFS_EVENT = 6'h10;
   localparam logic [5:0] DSSW_OFS_MASK = 6'h14;

   // ****************************************************************
   // Status word bit positions
   // ****************************************************************
   localparam int DSSW_ST_RUN_CMD = 1;
   localparam int DSSW_ST_OVERRIDE = 2;
   localparam int DSSW_ST_SECOND_RAMP = 5;
   localparam int DSSW_ST_CONFIG = 6;
   localparam int DSSW_ST_ALARM = 7;
   localparam int DSSW_ST_RUNNING = 8;
   localparam int DSSW_ST_ENABLED = 9;
   localparam int DSSW_ST_FORWARD = 10;
   localparam int DSSW_ST_INCHING = 11;
   localparam int DSSW_ST_REMOTE = 12;
   localparam int DSSW_ST_UNDERVOLT = 13;
   localparam int DSSW_ST_FAULT = 15;
   localparam logic [15:0] DSSW_ST_RESERVED_MASK = 16'h4019;

   // ****************************************************************
   // Event register bit positions
   // ****************************************************************
   localparam int DSSW_EV_FAULT = 0;
   localparam int DSSW_EV_ALARM = 1;
   localparam int DSSW_EV_UNDERVOLT = 2;
   localparam int DSSW_EV_CONFIG = 3;
   localparam int DSSW_EV_RUN_START = 4;
   localparam int DSSW_EV_RUN_STOP = 5;
   localparam int DSSW_EV_DIRECTION = 6;
   localparam int DSSW_EV_REMOTE = 7;
   localparam int DSSW_EV_SPEED = 8;
   localparam int DSSW_EV_W = 9;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] DSSW_RST_STATUS = 16'h0000;
   localparam logic [15:0] DSSW_RST_SPEED = 16'h0000;
   localparam logic [15:0] DSSW_RST_RATED_FREQ = 16'h0258;
   localparam logic [15:0] DSSW_RST_RATED_SPEED = 16'h06d6;
   localparam logic [8:0] DSSW_RST_EVENT = 9'h000;
   localparam logic [8:0] DSSW_RST_MASK = 9'h000;

   // ****************************************************************
   // Speed scaling constants
   // ****************************************************************
   localparam int DSSW_FRAC_BITS = 13;
   localparam logic [15:0] DSSW_SPEED_UNITY = 16'h2000;
   localparam logic [15:0] DSSW_SPEED_MAX = 16'h7fff;
   localparam logic [15:0] DSSW_SPEED_MIN = 16'h8000;
   localparam logic [4:0] DSSW_DIV_LAST = 5'h1d;

   // ****************************************************************
   // Types
   // ****************************************************************
   // Drive conditions from the surrounding drive logic, same clock
   typedef struct packed {
      logic runCommand;
      logic overrideActive;
      logic secondRamp;
      logic configState;
      logic alarm;
      logic running;
      logic enabled;
      logic forward;
      logic inchingActive;
      logic remote;
      logic undervoltage;
      logic fault;
   } dssw_cond_t;

   // Divider sequencer states
   typedef enum logic [2:0] {
      DSSW_DIV_IDLE = 3'b001,
      DSSW_DIV_RUN = 3'b010,
      DSSW_DIV_DONE = 3'b100
   } dssw_div_state_t;

endpackage : dssw_pkg

/* File: logic/dssw_speed_scaler.sv */
// Signed speed scaler: frequency times 8192 over rated frequency, saturated
`timescale 1ns/1ps
module dssw_speed_scaler
   import dssw_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Operands
   input wire logic signed [W-1:0] outputFreq,
   input wire logic [W-1:0] ratedFreq,
   // Result
   output logic [W-1:0] scaledSpeed,
   output logic done
);

   dssw_div_state_t state;
   logic [W+DSSW_FRAC_BITS:0] quo;
   logic [W:0] rem;
   logic [W-1:0] divisor;
   logic [4:0] step;
   logic neg;
   logic zeroIn;
   logic [W:0] magIn;
   logic [W:0] shifted;
   logic [W:0] diff;

   // Magnitude of the input and one restoring step
   always_comb begin
      magIn = outputFreq[W-1] ? ((W+1)'(0) - {outputFreq[W-1], outputFreq}) : {1'b0, outputFreq};
      shifted = {rem[W-1:0], quo[W+DSSW_FRAC_BITS]};
      diff = shifted - {1'b0, divisor};
   end

   // Sequencer: capture, divide, publish, repeat
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= DSSW_DIV_IDLE;
         quo <= '0;
         rem <= '0;
         divisor <= '0;
         step <= 5'h00;
         neg <= 1'b0;
         zeroIn <= 1'b1;
      end else begin
         case (state)
            DSSW_DIV_IDLE: begin
               quo <= {magIn, {DSSW_FRAC_BITS{1'b0}}}; // R15
               rem <= '0;
               divisor <= ratedFreq; // R18
               neg <= outputFreq[W-1];
               zeroIn <= (magIn == '0);
               step <= 5'h00;
               state <= DSSW_DIV_RUN;
            end
            DSSW_DIV_RUN: begin
               if (shifted >= {1'b0, divisor}) begin
                  rem <= diff;
                  quo <= {quo[W+DSSW_FRAC_BITS-1:0], 1'b1};
               end else begin
                  rem <= shifted;
                  quo <= {quo[W+DSSW_FRAC_BITS-1:0], 1'b0};
               end
               step <= step + 5'h01;
               if (step == DSSW_DIV_LAST) begin
                  state <= DSSW_DIV_DONE;
               end
            end
            DSSW_DIV_DONE: begin
               state <= DSSW_DIV_IDLE;
            end
            default: begin
               state <= DSSW_DIV_IDLE;
            end
         endcase
      end
   end

   // Saturate and sign the quotient
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scaledSpeed <= DSSW_RST_SPEED;
         done <= 1'b0;
      end else begin
         done <= (state == DSSW_DIV_DONE);
         if (state == DSSW_DIV_DONE) begin
            if (zeroIn) begin
               scaledSpeed <= '0; // R17
            end else if (divisor == '0) begin
               scaledSpeed <= neg ? DSSW_SPEED_MIN : DSSW_SPEED_MAX;
            end else if (neg) begin
               scaledSpeed <= (quo > {{(W+DSSW_FRAC_BITS-W+1){1'b0}}, DSSW_SPEED_MIN})
                  ? DSSW_SPEED_MIN : (W'(0) - quo[W-1:0]); // R14
            end else begin
               scaledSpeed <= (quo > {{(W+DSSW_FRAC_BITS-W+1){1'b0}}, DSSW_SPEED_MAX})
                  ? DSSW_SPEED_MAX : quo[W-1:0]; // R16
            end
         end
      end
   end

endmodule : dssw_speed_scaler

/* File: verif/dssw_status_regs_props.sv */
// Concurrent checks on the status and speed word slave ports
`timescale 1ns/1ps
module dssw_props
   import dssw_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Drive side
   input wire dssw_cond_t cond,
   input wire logic signed [W-1:0] outputFreq,
   input wire logic [15:0] statusWord,
   input wire logic [W-1:0] scaledSpeed,
   input wire logic irq
);
   // ****************************************************************
   // Helper logic
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [6:0] zeroCnt;
   // Cycles of steady zero frequency, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zeroCnt <= 7'h00;
      end else if (outputFreq != 0) begin
         zeroCnt <= 7'h00;
      end else if (zeroCnt != 7'h64) begin
         zeroCnt <= zeroCnt + 7'h01;
      end
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   run_bit_a: assert property (!$past(rst) |-> statusWord[1] == $past(cond.runCommand))
      else $error("run bit differs from run command");
   ovrd_bit_a: assert property (!$past(rst) |-> statusWord[2] == $past(cond.overrideActive))
      else $error("override bit differs from input");
   ramp_bit_a: assert property (!$past(rst) |-> statusWord[5] == $past(cond.secondRamp))
      else $error("second ramp bit differs from input");
   config_bit_a: assert property ($past(cond.configState) |-> statusWord[6])
      else $error("config bit low in configuration state");
   alarm_bit_a: assert property (!$past(rst) |-> statusWord[7] == $past(cond.alarm))
      else $error("alarm bit differs from input");
   running_bit_a: assert property (!$past(rst) |-> statusWord[8] == $past(cond.running))
      else $error("running bit differs from input");
   enabled_bit_a: assert property (statusWord[9] |-> $past(cond.enabled) && !statusWord[6])
      else $error("enabled bit without enable or in config");
   forward_bit_a: assert property (!$past(rst) |-> statusWord[10] == $past(cond.forward))
      else $error("forward bit differs from input");
   inch_bit_a: assert property (!$past(rst) |-> statusWord[11] == $past(cond.inchingActive))
      else $error("inching bit differs from input");
   remote_bit_a: assert property (!$past(rst) |-> statusWord[12] == $past(cond.remote))
      else $error("remote bit differs from input");
   fault_uv_a: assert property (!$past(rst) |-> statusWord[15] == $past(cond.fault)
      && statusWord[13] == $past(cond.undervoltage))
      else $error("fault or undervoltage bit differs from input");
   reserved_zero_a: assert property ((statusWord & DSSW_ST_RESERVED_MASK) == 16'h0000)
      else $error("reserved status bit set");
   one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("access not answered after one wait cycle");
   zero_speed_a: assert property (zeroCnt == 7'h64 |-> scaledSpeed == 16'h0000)
      else $error("speed word not zero at zero frequency");
   // Main scenarios
   read_done_c: cover property (read && !waitrequest);
   write_done_c: cover property (write && !waitrequest);
   irq_rise_c: cover property ($rose(irq));
endmodule : dssw_props

bind dssw_status_regs dssw_props #(.W(W)) dsswChk (.clk(clk), .rst(rst), .address(address),
   .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest), .cond(cond), .outputFreq(outputFreq),
   .statusWord(statusWord), .scaledSpeed(scaledSpeed), .irq(irq));

/* File: verif/drive_status_speed_words_bench.sv */
// Self-checking bench of the status and speed word slave
`timescale 1ns/1ps
module drive_status_speed_words_bench
   import dssw_pkg::*;
;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'h0;
   dssw_cond_t cond = '0;
   logic signed [15:0] outputFreq = 16'h0000;
   logic [31:0] readdata;
   logic waitrequest;
   logic [15:0] statusWord;
   logic [15:0] scaledSpeed;
   logic irq;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0001406c;
   logic [31:0] expQ[$];
   string nameQ[$];
   int pos[12] = '{15, 13, 12, 11, 10, 9, 8, 7, 6, 5, 2, 1};
   int fq[8] = '{0, 600, -600, 300, 2400, -3000, 2399, -2400};

   always #4 clk = ~clk;

   dssw_status_regs #(.W(16)) uut (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .cond(cond), .outputFreq(outputFreq),
      .statusWord(statusWord), .scaledSpeed(scaledSpeed), .irq(irq));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xorshift

   // Status word from condition inputs
   function automatic logic [31:0] expStatus(logic [11:0] c);
      logic [31:0] s;
      s = 32'h0;
      for (int k = 0; k < 12; k++) s[pos[k]] = c[k];
      s[9] = c[5] & ~c[8];
      return s;
   endfunction : expStatus

   // Saturated, truncated scaled speed
   function automatic logic [31:0] expSpeed(int f, int rf);
      int q;
      q = f * 8192 / rf;
      if (q > 32767) q = 32767;
      if (q < -32768) q = -32768;
      return {16'h0000, q[15:0]};
   endfunction : expSpeed

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic busWrite(logic [5:0] a, logic [31:0] d);
      address <= a;
      writedata <= d;
      byteenable <= 4'h3;
      write <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      @(posedge clk);
   endtask : busWrite

   task automatic busRead(logic [5:0] a, logic [31:0] exp, string what);
      expQ.push_back(exp);
      nameQ.push_back(what);
      address <= a;
      read <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
      @(posedge clk);
   endtask : busRead

   task automatic results();
      $display("counts: %0d checked, %0d wrong", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   // Completed reads against the oldest note
   always @(posedge clk) begin
      if (read && !waitrequest && expQ.size() > 0) begin
         check(nameQ.pop_front(), expQ.pop_front(), readdata);
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         results();
      end
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      logic [31:0] r;
      int f;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values and an unmapped place
      busRead(DSSW_OFS_RATED_FREQ, 32'h0000_0258, "rated frequency");
      busRead(DSSW_OFS_RATED_SPEED, 32'h0000_06d6, "rated speed");
      busRead(DSSW_OFS_EVENT, 32'h0, "event reset");
      busRead(DSSW_OFS_MASK, 32'h0, "mask reset");
      busRead(6'h18, 32'h0, "unmapped");
      busRead(DSSW_OFS_STATUS, 32'h0, "status reset");
      $display("test reset done");
      // Each condition alone, then config with enable, then random mixes
      for (int k = 0; k < 30; k++) begin
         r = (k < 12) ? (32'h1 << k) : (k == 12) ? 32'h120 : xorshift();
         cond <= dssw_cond_t'(r[11:0]);
         repeat (2) @(posedge clk);
         busRead(DSSW_OFS_STATUS, expStatus(r[11:0]), "status");
      end
      busWrite(DSSW_OFS_STATUS, 32'h0000_ffff);
      busRead(DSSW_OFS_STATUS, expStatus(r[11:0]), "status after write");
      busWrite(DSSW_OFS_SPEED, 32'h0000_1234);
      busRead(DSSW_OFS_SPEED, 32'h0, "speed after write");
      $display("test status done");
      // Boundary and random frequencies against the default rated value
      cond <= '0;
      for (int i = 0; i < 20; i++) begin
         r = xorshift();
         f = (i < 8) ? fq[i] : $signed(r[15:0]) % 2400;
         outputFreq <= f[15:0];
         repeat (80) @(posedge clk);
         busRead(DSSW_OFS_SPEED, expSpeed(f, 600), "scaled speed");
      end
      // Rated speed must not matter, rated frequency must
      busWrite(DSSW_OFS_RATED_SPEED, 32'h0000_0100);
      outputFreq <= 16'sd600;
      repeat (80) @(posedge clk);
      busRead(DSSW_OFS_SPEED, 32'h0000_2000, "speed at rated");
      busWrite(DSSW_OFS_RATED_FREQ, 32'h0000_03e8);
      outputFreq <= -16'sd500;
      repeat (80) @(posedge clk);
      busRead(DSSW_OFS_SPEED, expSpeed(-500, 1000), "speed new rated");
      busWrite(DSSW_OFS_RATED_FREQ, 32'h0000_0000);
      repeat (80) @(posedge clk);
      busRead(DSSW_OFS_SPEED, 32'h0000_8000, "speed zero rated");
      busRead(DSSW_OFS_STATUS, 32'h0000_0040, "status zero rated");
      $display("test speed done");
      // Event set, masked, unmasked and cleared
      outputFreq <= 16'h0000;
      repeat (80) @(posedge clk);
      busWrite(DSSW_OFS_EVENT, 32'h0000_01ff);
      busRead(DSSW_OFS_EVENT, 32'h0, "event cleared");
      cond <= dssw_cond_t'(12'h001);
      repeat (4) @(posedge clk);
      busRead(DSSW_OFS_EVENT, 32'h1, "fault event");
      check("irq masked", 32'h0, {31'h0, irq});
      busWrite(DSSW_OFS_MASK, 32'h0000_0001);
      busRead(DSSW_OFS_MASK, 32'h1, "mask");
      check("irq unmasked", 32'h1, {31'h0, irq});
      busWrite(DSSW_OFS_EVENT, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check("irq cleared", 32'h0, {31'h0, irq});
      busRead(DSSW_OFS_EVENT, 32'h0, "event after clear");
      $display("test interrupt done");
      check("pending notes", 32'h0, expQ.size());
      results();
   end
endmodule : drive_status_speed_words_bench
